// *** inc/ssol_pkg.sv ***
// Constants for the servo status output logic.
// Assumes a 100 MHz ref_clk and an Avalon-MM register port.
`default_nettype none

package ssol_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CTL_CYCLE_NS    = 100;
  localparam int CTL_DIV         = CTL_CYCLE_NS / CLK_PERIOD_NS;
  localparam int FAN_LOCK_MS     = 1000;
  localparam int FAN_LOCK_CYCLES = FAN_LOCK_MS * (1000000 / CLK_PERIOD_NS);

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_SELECT   = 5'h04;
  localparam logic [4:0] OFS_POS_RNG  = 5'h08;
  localparam logic [4:0] OFS_ZERO_THR = 5'h0c;
  localparam logic [4:0] OFS_AT_THR   = 5'h10;
  localparam logic [4:0] OFS_BRAKE    = 5'h14;
  localparam logic [4:0] OFS_STATUS   = 5'h18;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_METH_LSB = 4;
  localparam int SEL_TRQ_LSB   = 0;
  localparam int SEL_ZERO_LSB  = 4;
  localparam int BRK_STAND_LSB = 0;
  localparam int BRK_MOT_LSB   = 16;

  // Reset values
  localparam logic [3:0] TRQ_SEL_RST  = 4'h0;
  localparam logic [3:0] ZERO_SEL_RST = 4'h1;

  // Overload warning fraction in percent
  localparam logic [6:0] OVL_PCT  = 7'h55;
  localparam logic [6:0] PCT_FULL = 7'h64;

  // ==========================================================
  // Enumerations
  typedef enum logic [2:0] {
    SSOL_MODE_POS   = 3'b000,
    SSOL_MODE_VEL   = 3'b001,
    SSOL_MODE_TRQ   = 3'b010,
    SSOL_MODE_FULLC = 3'b011
  } ssol_mode_t;

  typedef enum logic [1:0] {
    SSOL_METH_LEVEL = 2'b00,
    SSOL_METH_IDLE  = 2'b01,
    SSOL_METH_HOLD  = 2'b10,
    SSOL_METH_RSVD  = 2'b11
  } ssol_meth_t;

  typedef enum logic [1:0] {
    SSOL_BRK_HELD    = 2'b00,
    SSOL_BRK_RELEASE = 2'b01,
    SSOL_BRK_WAIT    = 2'b10
  } ssol_brk_t;

  localparam logic [3:0] SEL_CLAMP = 4'h0;
  localparam logic [3:0] SEL_ZERO  = 4'h1;
  localparam logic [3:0] SEL_ANYW  = 4'h2;
  localparam logic [3:0] SEL_REGEN = 4'h3;
  localparam logic [3:0] SEL_OVL   = 4'h4;
  localparam logic [3:0] SEL_BATT  = 4'h5;
  localparam logic [3:0] SEL_FAN   = 4'h6;
  localparam logic [3:0] SEL_SCALE = 4'h7;
  localparam logic [3:0] SEL_MATCH = 4'h8;

endpackage

`default_nettype wire

// *** hw/ssol_top.sv ***
// Status output logic of a servo drive, with its setting registers.
// Assumes pin-level status inputs are asynchronous and numeric
// inputs come from drive logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none

module ssol_top
  import ssol_pkg::*;
#(
  parameter int DW              = 16,
  parameter int CYCLE_DIV       = CTL_DIV,
  parameter int FAN_LOCK_CNT    = FAN_LOCK_CYCLES
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output var  logic [31:0]   avs_readdata,
  output var  logic          avs_waitrequest,
  input  wire logic          control_supply_on,
  input  wire logic          main_supply_on,
  input  wire logic          alarm_active,
  input  wire logic          servo_on,
  input  wire logic          torque_limit_hit,
  input  wire logic          regen_warn,
  input  wire logic          battery_low,
  input  wire logic          fan_stalled,
  input  wire logic          scale_warn,
  input  wire logic          command_active,
  input  wire logic [DW-1:0] position_deviation,
  input  wire logic [DW-1:0] full_closed_deviation,
  input  wire logic [DW-1:0] motor_speed,
  input  wire logic [DW-1:0] speed_command,
  input  wire logic [DW-1:0] load_level,
  input  wire logic [DW-1:0] overload_trip_level,
  output var  logic          brake_release_out,
  output var  logic          servo_ready_out,
  output var  logic          alarm_n_out,
  output var  logic          in_position_out,
  output var  logic          zero_speed_out,
  output var  logic          torque_clamped_out
);

  // ==========================================================
  // Elaboration checks
  generate
    if (DW < 2 || DW > 16 || CYCLE_DIV < 1 || FAN_LOCK_CNT < 1) begin : g_bad
      $error("ssol_top: unsupported parameter value");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;

  assign pin_raw = {command_active, scale_warn, fan_stalled, battery_low,
                    regen_warn, torque_limit_hit, servo_on, alarm_active,
                    main_supply_on, control_supply_on};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic s_ctl, s_main, s_alarm, s_servo, s_clamp;
  logic s_regen, s_batt, s_fan, s_scale, s_cmd;
  assign {s_cmd, s_scale, s_fan, s_batt, s_regen, s_clamp, s_servo, s_alarm, s_main, s_ctl} = sync2;

  // ==========================================================
  // Control cycle divider
  localparam int TW = $clog2(CYCLE_DIV + 1);
  logic [TW-1:0] tick_cnt;
  logic          ctl_tick;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      ctl_tick <= 1'b0;
    end else if (tick_cnt == TW'(CYCLE_DIV - 1)) begin
      tick_cnt <= '0;
      ctl_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ctl_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Registers and Avalon-MM slave
  ssol_mode_t    mode;
  ssol_meth_t    meth;
  logic [3:0]    torque_out_select;
  logic [3:0]    zero_out_select;
  logic [DW-1:0] in_position_range;
  logic [DW-1:0] zero_speed_threshold;
  logic [DW-1:0] speed_reached_flag_threshold;
  logic [15:0]   brake_timing_standstill;
  logic [15:0]   brake_timing_motion;
  logic [5:0]    status_vec;

  logic wr_take;
  assign wr_take = avs_write && !avs_waitrequest;

  // One wait state: answer comes in the cycle after the request is seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode                    <= SSOL_MODE_POS;
      meth                    <= SSOL_METH_LEVEL;
      torque_out_select       <= TRQ_SEL_RST;
      zero_out_select         <= ZERO_SEL_RST;
      in_position_range       <= '0;
      zero_speed_threshold    <= '0;
      speed_reached_flag_threshold      <= '0;
      brake_timing_standstill <= '0;
      brake_timing_motion     <= '0;
    end else if (wr_take) begin
      case (avs_address)
        OFS_CTRL: begin
          mode <= ssol_mode_t'(avs_writedata[CTRL_MODE_LSB +: 3]);
          meth <= ssol_meth_t'(avs_writedata[CTRL_METH_LSB +: 2]);
        end
        OFS_SELECT: begin
          torque_out_select <= avs_writedata[SEL_TRQ_LSB +: 4];
          zero_out_select   <= avs_writedata[SEL_ZERO_LSB +: 4];
        end
        OFS_POS_RNG:  in_position_range    <= avs_writedata[DW-1:0];
        OFS_ZERO_THR: zero_speed_threshold <= avs_writedata[DW-1:0];
        OFS_AT_THR:   speed_reached_flag_threshold   <= avs_writedata[DW-1:0];
        OFS_BRAKE: begin
          brake_timing_standstill <= avs_writedata[BRK_STAND_LSB +: 16];
          brake_timing_motion     <= avs_writedata[BRK_MOT_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= '0;
      case (avs_address)
        OFS_CTRL: begin
          avs_readdata[CTRL_MODE_LSB +: 3] <= mode;
          avs_readdata[CTRL_METH_LSB +: 2] <= meth;
        end
        OFS_SELECT: begin
          avs_readdata[SEL_TRQ_LSB +: 4]  <= torque_out_select;
          avs_readdata[SEL_ZERO_LSB +: 4] <= zero_out_select;
        end
        OFS_POS_RNG:  avs_readdata[DW-1:0] <= in_position_range;
        OFS_ZERO_THR: avs_readdata[DW-1:0] <= zero_speed_threshold;
        OFS_AT_THR:   avs_readdata[DW-1:0] <= speed_reached_flag_threshold;
        OFS_BRAKE: begin
          avs_readdata[BRK_STAND_LSB +: 16] <= brake_timing_standstill;
          avs_readdata[BRK_MOT_LSB +: 16]   <= brake_timing_motion;
        end
        OFS_STATUS:   avs_readdata[5:0] <= status_vec;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Comparisons
  function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
    mag = v[DW-1] ? DW'(-v) : v;
  endfunction

  logic [DW-1:0] pos_mag, fc_mag, spd_mag, diff_mag;
  logic          below_zero, above_at, match_ok, ovl_warn;
  logic [DW+6:0] load_scaled, trip_scaled;

  assign pos_mag     = mag(position_deviation);
  assign fc_mag      = mag(full_closed_deviation);
  assign spd_mag     = mag(motor_speed);
  assign diff_mag    = mag(DW'(motor_speed - speed_command));
  assign below_zero  = spd_mag < zero_speed_threshold;
  assign above_at    = spd_mag > speed_reached_flag_threshold;
  // Code 8 shares the zero-speed threshold as its window
  assign match_ok    = diff_mag < zero_speed_threshold;
  // Percent scaling avoids a divider at the cost of two multipliers
  assign load_scaled = (DW+7)'(load_level) * (DW+7)'(PCT_FULL);
  assign trip_scaled = (DW+7)'(overload_trip_level) * (DW+7)'(OVL_PCT);
  assign ovl_warn    = load_scaled > trip_scaled;

  // ==========================================================
  // Fan lock timer, counted in ref_clk cycles
  logic [31:0] fan_cnt;
  logic        fan_lock;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_cnt  <= '0;
      fan_lock <= 1'b0;
    end else if (!s_fan) begin
      fan_cnt  <= '0;
      fan_lock <= 1'b0;
    end else if (fan_cnt >= 32'(FAN_LOCK_CNT)) begin
      fan_lock <= 1'b1;
    end else begin
      fan_cnt <= fan_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Selector table
  logic [8:0] cond;
  assign cond = {match_ok, s_scale, fan_lock, s_batt, ovl_warn, s_regen,
                 s_regen | ovl_warn | s_batt | fan_lock | s_scale,
                 below_zero,
                 s_servo & s_clamp};

  function automatic logic sel_out(input logic [3:0] code, input logic [8:0] c,
                                   input ssol_mode_t m);
    case (code)
      SEL_CLAMP, SEL_ZERO, SEL_ANYW, SEL_REGEN,
      SEL_OVL, SEL_BATT, SEL_FAN: sel_out = c[code];
      SEL_SCALE: sel_out = c[code] && (m == SSOL_MODE_FULLC);
      SEL_MATCH: sel_out = c[code] && (m == SSOL_MODE_VEL || m == SSOL_MODE_TRQ);
      default:   sel_out = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // In-position / speed_reached_flag
  logic pos_reach, pos_hold, next_inpos;
  assign pos_reach = (mode == SSOL_MODE_FULLC) ? (fc_mag < in_position_range)
                                               : (pos_mag < in_position_range);

  always_comb begin
    case (meth)
      SSOL_METH_LEVEL: next_inpos = pos_reach;
      SSOL_METH_HOLD:  next_inpos = (pos_reach || pos_hold) && !s_cmd;
      default:         next_inpos = pos_reach && !s_cmd;
    endcase
    if (mode == SSOL_MODE_VEL || mode == SSOL_MODE_TRQ) begin
      next_inpos = above_at;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_hold <= 1'b0;
    end else if (ctl_tick) begin
      pos_hold <= next_inpos && !s_cmd;
    end
  end

  // ==========================================================
  // Brake release sequencer, timings in control cycles
  ssol_brk_t   brk_state;
  logic [15:0] brk_cnt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_state <= SSOL_BRK_HELD;
      brk_cnt   <= '0;
    end else if (ctl_tick) begin
      case (brk_state)
        SSOL_BRK_HELD: if (s_servo && !s_alarm) begin
          brk_state <= SSOL_BRK_RELEASE;
        end
        SSOL_BRK_RELEASE: if (!s_servo || s_alarm) begin
          brk_state <= SSOL_BRK_WAIT;
          brk_cnt   <= below_zero ? brake_timing_standstill : brake_timing_motion;
        end
        SSOL_BRK_WAIT: begin
          if (brk_cnt == '0 || (!below_zero && s_alarm)) begin
            brk_state <= SSOL_BRK_HELD;
          end else begin
            brk_cnt <= brk_cnt - 16'h1;
          end
        end
        default: brk_state <= SSOL_BRK_HELD;
      endcase
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_release_out  <= 1'b0;
      servo_ready_out    <= 1'b0;
      alarm_n_out        <= 1'b0;
      in_position_out    <= 1'b0;
      zero_speed_out     <= 1'b0;
      torque_clamped_out <= 1'b0;
    end else if (ctl_tick) begin
      brake_release_out  <= (brk_state != SSOL_BRK_HELD);
      servo_ready_out    <= s_ctl && s_main && !s_alarm;
      alarm_n_out        <= !s_alarm;
      in_position_out    <= next_inpos;
      zero_speed_out     <= sel_out(zero_out_select, cond, mode);
      torque_clamped_out <= sel_out(torque_out_select, cond, mode);
    end
  end

  assign status_vec = {torque_clamped_out, zero_speed_out, in_position_out,
                       alarm_n_out, servo_ready_out, brake_release_out};

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence seq_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_READY: assert property (ctl_tick |=> servo_ready_out == $past(s_ctl && s_main && !s_alarm))
    else $error("servo ready mismatch");
  AST_ALARM: assert property (ctl_tick && s_alarm |=> !alarm_n_out)
    else $error("alarm output not low");
  AST_ZERO: assert property (ctl_tick && zero_out_select == SEL_ZERO |=> zero_speed_out == $past(below_zero))
    else $error("zero speed output mismatch");
  AST_CLAMP: assert property (ctl_tick && torque_out_select == SEL_CLAMP && !s_servo |=> !torque_clamped_out)
    else $error("clamp output without servo on");
  AST_BADSEL: assert property (ctl_tick && zero_out_select > SEL_MATCH |=> !zero_speed_out)
    else $error("invalid code drives output");
  AST_ATSPD: assert property (ctl_tick && mode == SSOL_MODE_VEL |=> in_position_out == $past(above_at))
    else $error("speed_reached_flag mismatch");
  AST_POS: assert property (ctl_tick && mode == SSOL_MODE_POS && meth == SSOL_METH_LEVEL
                            |=> in_position_out == $past(pos_mag < in_position_range))
    else $error("in position mismatch");
  AST_STABLE: assert property (!ctl_tick |=> $stable(zero_speed_out) && $stable(in_position_out))
    else $error("output changed off cycle");
  AST_BRAKE: assert property (ctl_tick && brk_state == SSOL_BRK_HELD |=> !brake_release_out)
    else $error("brake released while held");
  AST_BUS: assert property (seq_req |=> seq_ack)
    else $error("bus answer not in one wait state");

endmodule

`default_nettype wire

// *** sim/ssol_host_model.sv ***
// Host motion controller model: issues servo-on and motion commands, samples status flags.
// Assumes it shares ref_clk and rst_n with the drive under test.
`timescale 1ns/10ps
`default_nettype none

module ssol_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       want_servo_on,
  input  wire logic       want_motion,
  input  wire logic [5:0] drive_flags,
  output var  logic       servo_on,
  output var  logic       command_active,
  output var  logic [5:0] flags_seen
);
  // ==========================================================
  // Command latch
  // Commands move only just after an edge, like a controller output port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on       <= 1'b0;
      command_active <= 1'b0;
    end else begin
      servo_on       <= want_servo_on;
      command_active <= want_motion;
    end
  end

  // ==========================================================
  // Flag sampling
  // Drive flags are registered levels, so one sample per clock is enough
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_seen <= 6'h00;
    end else begin
      flags_seen <= drive_flags;
    end
  end
endmodule

`default_nettype wire

// *** sim/ssol_top_tb_top.sv ***
// Self-checking bench for the servo status output logic.
// Assumes register access over Avalon-MM and a host model on the command pins.
`timescale 1ns/10ps
`default_nettype none

`define SSOL_CHK(got, exp, msg) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t %s got=%0h exp=%0h", $time, msg, got, exp); \
    end \
  end

module ssol_top_tb_top
  import ssol_pkg::*;
;
  // ==========================================================
  // Signals
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        control_supply_on = 1'b0, main_supply_on = 1'b0, alarm_active = 1'b0;
  logic        torque_limit_hit = 1'b0, regen_warn = 1'b0, battery_low = 1'b0;
  logic        fan_stalled = 1'b0, scale_warn = 1'b0;
  logic        want_servo = 1'b0, want_motion = 1'b0;
  logic        servo_on, command_active;
  logic [15:0] position_deviation = 16'h0, full_closed_deviation = 16'h0;
  logic [15:0] motor_speed = 16'h0, speed_command = 16'h0;
  logic [15:0] load_level = 16'h0, overload_trip_level = 16'h0064;
  logic        brake_release_out, servo_ready_out, alarm_n_out;
  logic        in_position_out, zero_speed_out, torque_clamped_out;
  logic [5:0]  flags_seen;
  logic [31:0] rdata;
  int          bad_count = 0;
  int          checks_done = 0;
  // Boundary tables: dv is one below, at, and a negative just inside the limit; sp is one above, at, and a negative well past it
  logic [15:0] dv [3] = '{16'h0063, 16'h0064, 16'hff9d};
  logic [15:0] sp [3] = '{16'h01f5, 16'h01f4, 16'hfda8};

  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // Design and host model
  // Short counts keep the fan timer and control cycle quick in simulation
  ssol_top #(.DW(16), .CYCLE_DIV(2), .FAN_LOCK_CNT(50)) i_ssol_top (
    .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .control_supply_on, .main_supply_on,
    .alarm_active, .servo_on, .torque_limit_hit, .regen_warn, .battery_low,
    .fan_stalled, .scale_warn, .command_active, .position_deviation,
    .full_closed_deviation, .motor_speed, .speed_command, .load_level,
    .overload_trip_level, .brake_release_out, .servo_ready_out, .alarm_n_out,
    .in_position_out, .zero_speed_out, .torque_clamped_out
  );

  ssol_host_model i_ssol_host_model (
    .ref_clk, .rst_n, .want_servo_on(want_servo), .want_motion, .servo_on, .command_active,
    .drive_flags({torque_clamped_out, zero_speed_out, in_position_out,
                  alarm_n_out, servo_ready_out, brake_release_out}),
    .flags_seen
  );

  // ==========================================================
  // Tasks
  task test_done;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("CHECK FAILED t=%0t bus wait timed out", $time);
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus_xfer(1'b0, a, 32'h0);
  endtask

  // Pin sync, one control cycle and the output register all fit in ten clocks
  task automatic settle;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  task automatic run_tab(input int which, input logic [2:0] ex, input string nm);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      case (which)
        0: position_deviation <= dv[i];
        1: full_closed_deviation <= dv[i];
        default: motor_speed <= sp[i];
      endcase
      settle();
      `SSOL_CHK(in_position_out, ex[2-i], nm)
    end
  endtask

  // Drives the cause of one selector code; off leaves it just short of firing
  // Values are worked out first so that each input is driven once per edge
  task automatic set_cond(input int code, input logic on);
    logic [1:0]  svc;
    logic [3:0]  wrn;
    logic [15:0] spd;
    logic [15:0] cmd;
    logic [15:0] ld;
    svc = 2'b00;
    wrn = 4'h0;
    spd = 16'd1000;
    cmd = 16'd1010;
    ld  = 16'd85;
    case (code)
      0: svc = {on, 1'b1};
      1: spd = on ? 16'd5 : 16'd10;
      2, 3: wrn[3] = on;
      4: ld = on ? 16'd86 : 16'd85;
      5: wrn[2] = on;
      6: wrn[1] = on;
      7: wrn[0] = on;
      8: cmd = on ? 16'd1009 : 16'd1010;
      default: begin
        svc = {2{on}};
        wrn = {4{on}};
        ld  = 16'd86;
      end
    endcase
    @(posedge ref_clk);
    {want_servo, torque_limit_hit} <= svc;
    {regen_warn, battery_low, fan_stalled, scale_warn} <= wrn;
    motor_speed <= spd;
    speed_command <= cmd;
    load_level <= ld;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [2:0] md;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_SELECT);
    `SSOL_CHK(rdata, 32'h0000_0010, "select reset value")
    rd(5'h1c);
    `SSOL_CHK(rdata, 32'h0, "unmapped read")
    $display("test reset_values done");

    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {main_supply_on, control_supply_on} <= 2'(i);
      settle();
      `SSOL_CHK(servo_ready_out, (i == 3), "ready vs supplies")
    end
    @(posedge ref_clk);
    alarm_active <= 1'b1;
    settle();
    `SSOL_CHK(alarm_n_out, 1'b0, "alarm low")
    `SSOL_CHK(servo_ready_out, 1'b0, "ready in alarm")
    @(posedge ref_clk);
    alarm_active <= 1'b0;
    settle();
    `SSOL_CHK(alarm_n_out, 1'b1, "alarm released")
    $display("test supply_alarm done");

    wr(OFS_POS_RNG, 32'd100);
    wr(OFS_CTRL, 32'(SSOL_MODE_POS));
    run_tab(0, 3'b101, "position window");
    // Outputs move on odd edges after reset here; land the change on one so the next edge has no tick
    repeat (2) @(posedge ref_clk);
    position_deviation <= 16'h00c8;
    @(posedge ref_clk);
    #1;
    `SSOL_CHK(in_position_out, 1'b1, "output held until tick")
    settle();
    `SSOL_CHK(in_position_out, 1'b0, "position far")
    wr(OFS_CTRL, 32'h10 | 32'(SSOL_MODE_POS));
    @(posedge ref_clk);
    position_deviation <= 16'h0;
    want_motion <= 1'b1;
    settle();
    `SSOL_CHK(in_position_out, 1'b0, "method suppress in motion")
    @(posedge ref_clk);
    want_motion <= 1'b0;
    settle();
    `SSOL_CHK(in_position_out, 1'b1, "method idle")
    rd(OFS_STATUS);
    `SSOL_CHK(rdata[5:0], flags_seen, "status mirrors pins")
    `SSOL_CHK(rdata & 32'hffff_ffce, 32'h0000_000e, "status fields")
    wr(OFS_CTRL, 32'h20 | 32'(SSOL_MODE_POS));
    @(posedge ref_clk);
    position_deviation <= 16'h00c8;
    settle();
    `SSOL_CHK(in_position_out, 1'b1, "method hold")
    @(posedge ref_clk);
    want_motion <= 1'b1;
    settle();
    `SSOL_CHK(in_position_out, 1'b0, "hold dropped by command")
    @(posedge ref_clk);
    want_motion <= 1'b0;
    settle();
    `SSOL_CHK(in_position_out, 1'b0, "hold stays cleared")
    wr(OFS_CTRL, 32'(SSOL_MODE_FULLC));
    @(posedge ref_clk);
    position_deviation <= 16'd500;
    run_tab(1, 3'b101, "full closed window");
    $display("test in_position done");

    wr(OFS_AT_THR, 32'd500);
    wr(OFS_CTRL, 32'(SSOL_MODE_VEL));
    run_tab(2, 3'b101, "speed_reached_flag");
    wr(OFS_CTRL, 32'(SSOL_MODE_TRQ));
    settle();
    `SSOL_CHK(in_position_out, 1'b1, "speed_reached_flag torque mode")
    $display("test speed_reached_flag done");

    wr(OFS_ZERO_THR, 32'd10);
    for (int c = 0; c < 16; c++) begin
      md = (c == 7) ? SSOL_MODE_FULLC : (c == 8) ? SSOL_MODE_VEL : SSOL_MODE_POS;
      wr(OFS_CTRL, 32'(md));
      wr(OFS_SELECT, {24'h0, 4'(c), 4'(c)});
      set_cond(c, 1'b0);
      settle();
      `SSOL_CHK({zero_speed_out, torque_clamped_out}, 2'b00, "selector idle")
      set_cond(c, 1'b1);
      settle();
      if (c == 6) begin
        `SSOL_CHK(zero_speed_out, 1'b0, "fan stall too short")
        repeat (70) @(posedge ref_clk);
        #1;
      end
      `SSOL_CHK({zero_speed_out, torque_clamped_out}, {2{c <= 8}}, "selector code")
    end
    for (int c = 7; c < 9; c++) begin
      wr(OFS_CTRL, 32'(SSOL_MODE_POS));
      wr(OFS_SELECT, {24'h0, 4'(c), 4'(c)});
      set_cond(c, 1'b1);
      settle();
      `SSOL_CHK({zero_speed_out, torque_clamped_out}, 2'b00, "code outside its mode")
    end
    $display("test selectors done");

    wr(OFS_BRAKE, 32'h0030_0008);
    set_cond(0, 1'b0);
    @(posedge ref_clk);
    {want_servo, torque_limit_hit, motor_speed} <= {1'b1, 1'b0, 16'h0};
    settle();
    `SSOL_CHK(brake_release_out, 1'b1, "brake released at servo on")
    @(posedge ref_clk);
    want_servo <= 1'b0;
    settle();
    `SSOL_CHK(brake_release_out, 1'b1, "brake held open for standstill time")
    repeat (25) @(posedge ref_clk);
    #1;
    `SSOL_CHK(brake_release_out, 1'b0, "brake engaged after delay")
    @(posedge ref_clk);
    {want_servo, motor_speed} <= {1'b1, 16'd1000};
    settle();
    @(posedge ref_clk);
    want_servo <= 1'b0;
    repeat (35) @(posedge ref_clk);
    #1;
    `SSOL_CHK(brake_release_out, 1'b1, "brake held open for motion time")
    repeat (80) @(posedge ref_clk);
    #1;
    `SSOL_CHK(brake_release_out, 1'b0, "brake engaged after motion delay")
    $display("test brake done");
    test_done();
  end
endmodule

`default_nettype wire
